/* File: rtl/iosa_access_decode.v */
`timescale 1ns/1ps
`include "iosa_consts.vh"

module iosa_access_decode #(
  parameter NV_WRITE_CYCLES = `IOSA_NV_WRITE_CYCLES
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       porRst_b,
  input  wire       compatModePin,
  input  wire       supplyOkPin,
  input  wire       opValid,
  input  wire [2:0] opKind,
  input  wire [7:0] opAddr,
  input  wire [2:0] opBit,
  input  wire [7:0] opWrData,
  input  wire [7:0] hwFlagSet,
  input  wire       nvWriteStart,
  output reg  [7:0] rdData,
  output reg        rdValid,
  output reg        skipTaken,
  output reg        accessError,
  output reg  [7:0] flagStatus,
  output reg  [7:0] extMemCtrlA,
  output reg  [7:0] extMemCtrlB,
  output reg        nvWriteBusy,
  output reg        nvWriteDone
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // port and bit ops give a short address; data ops give a data address
  function [8:0] toDataAddr;
    input [2:0] kind;
    input [7:0] addr;
    begin
      if (kind == `IOSA_OP_DATA_LOAD || kind == `IOSA_OP_DATA_WRITE) begin
        toDataAddr = {1'b0, addr};
      end else begin
        toDataAddr = {1'b0, addr} + {1'b0, `IOSA_DATA_IO_OFFSET};
      end
    end
  endfunction

  // legality of one operation on its address
  function opLegal;
    input [2:0] kind;
    input [7:0] addr;
    begin
      case (kind)
        `IOSA_OP_PORT_READ,
        `IOSA_OP_PORT_WRITE:  opLegal = (addr <= `IOSA_PORT_LAST);
        `IOSA_OP_DATA_LOAD,
        `IOSA_OP_DATA_WRITE:  opLegal = (addr >= `IOSA_DATA_IO_OFFSET);
        default:              opLegal = (addr <= `IOSA_BIT_LAST);
      endcase
    end
  endfunction

  // extended address that holds no register outside legacy mode
  function extReserved;
    input [7:0] daddr;
    begin
      extReserved = (daddr > `IOSA_EXT_USED_LAST);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] compatSync;
  reg [1:0] supplySync;
  wire      compatMode = compatSync[1];
  wire      supplyOk   = supplySync[1];

  // two flops per pin
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compatSync <= 2'h0;
    end else begin
      compatSync <= {compatSync[0], compatModePin};
    end
  end

  // supply sense runs on power-on reset so nv engine sees it through rst_b
  always @(posedge clk or negedge porRst_b) begin
    if (!porRst_b) begin
      supplySync <= 2'h0;
    end else begin
      supplySync <= {supplySync[0], supplyOkPin};
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [7:0] ioMem  [0:63];
  reg [7:0] extMem [0:159];
  reg [7:0] sramExt[0:159];

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire [8:0] dAddrW   = toDataAddr(opKind, opAddr);
  wire [7:0] dAddr    = dAddrW[7:0];
  wire       legal    = opLegal(opKind, opAddr) && !dAddrW[8];
  wire       isExt    = (dAddr >= `IOSA_EXT_FIRST);
  wire [5:0] ioIdx    = dAddr[5:0] - 6'h20;
  wire [7:0] extIdx   = dAddr - `IOSA_EXT_FIRST;
  wire       isFlag   = !isExt && (ioIdx == `IOSA_FLAG_ADDR);
  wire       isXmcA   = (dAddr == `IOSA_XMC_A_ADDR);
  wire       isXmcB   = (dAddr == `IOSA_XMC_B_ADDR);
  wire       isWrite  = (opKind == `IOSA_OP_PORT_WRITE) ||
                        (opKind == `IOSA_OP_DATA_WRITE) ||
                        (opKind == `IOSA_OP_BIT_SET) ||
                        (opKind == `IOSA_OP_BIT_CLEAR);
  wire       isBitMod = (opKind == `IOSA_OP_BIT_SET) || (opKind == `IOSA_OP_BIT_CLEAR);
  wire       isTest   = (opKind == `IOSA_OP_SKIP_IF_SET) || (opKind == `IOSA_OP_SKIP_IF_CLR);
  wire [7:0] bitMask  = 8'h01 << opBit;

  // current content of the addressed location
  reg [7:0] curValue;
  always @* begin
    curValue = 8'h00;
    if (!isExt) begin
      curValue = isFlag ? flagStatus : ioMem[ioIdx];
    end else if (compatMode) begin
      curValue = sramExt[extIdx[7:0]];
    end else if (isXmcA) begin
      curValue = extMemCtrlA;
    end else if (isXmcB) begin
      curValue = extMemCtrlB;
    end else if (!extReserved(dAddr)) begin
      curValue = extMem[extIdx[7:0]];
    end
  end

  // byte to store: whole-register read-modify-write for bit ops
  reg [7:0] storeValue;
  always @* begin
    storeValue = opWrData;
    if (opKind == `IOSA_OP_BIT_SET) begin
      storeValue = curValue | bitMask;
    end else if (opKind == `IOSA_OP_BIT_CLEAR) begin
      storeValue = curValue & ~bitMask;
    end
  end

  wire doWrite   = opValid && legal && isWrite;
  wire flagWrite = doWrite && isFlag;

  // ----------------------------------------------------------------
  // answer to the core
  // ----------------------------------------------------------------

  // read data, skip decision and error, one cycle after the request
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData      <= 8'h00;
      rdValid     <= 1'b0;
      skipTaken   <= 1'b0;
      accessError <= 1'b0;
    end else begin
      rdValid     <= opValid && legal && !isWrite && !isTest;
      accessError <= opValid && !legal;
      skipTaken   <= 1'b0;
      if (opValid && legal && !isWrite && !isTest) begin
        rdData <= curValue;
      end
      if (opValid && legal && isTest) begin
        skipTaken <= (opKind == `IOSA_OP_SKIP_IF_SET) ?
                     curValue[opBit] : !curValue[opBit];
      end
    end
  end

  // ----------------------------------------------------------------
  // register file writes
  // ----------------------------------------------------------------
  genvar gi;

  // plain short I/O locations
  generate
    for (gi = 0; gi < 64; gi = gi + 1) begin : gIo
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ioMem[gi] <= `IOSA_REG_RESET;
        end else if (doWrite && !isExt && !isFlag && ioIdx == gi) begin
          ioMem[gi] <= storeValue;
        end
      end
    end
  endgenerate

  // extended peripheral locations, dormant in legacy mode
  generate
    for (gi = 0; gi < 160; gi = gi + 1) begin : gExt
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          extMem[gi] <= `IOSA_REG_RESET;
        end else if (doWrite && isExt && !compatMode && !extReserved(dAddr) &&
                     !isXmcA && !isXmcB && extIdx == gi) begin
          extMem[gi] <= storeValue;
        end
      end
    end
  endgenerate

  // legacy SRAM at the extended addresses, no reset like any SRAM
  always @(posedge clk) begin
    if (doWrite && isExt && compatMode) begin
      sramExt[extIdx[7:0]] <= storeValue;
    end
  end

  // external memory control pair; cleared and locked in legacy mode
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extMemCtrlA <= `IOSA_REG_RESET;
      extMemCtrlB <= `IOSA_REG_RESET;
    end else if (compatMode) begin
      extMemCtrlA <= `IOSA_REG_RESET;
      extMemCtrlB <= `IOSA_REG_RESET;
    end else if (doWrite && isXmcA) begin
      extMemCtrlA <= storeValue;
    end else if (doWrite && isXmcB) begin
      extMemCtrlB <= storeValue;
    end
  end

  // write-one-to-clear flags; a hardware set in the same cycle wins
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flagStatus <= `IOSA_REG_RESET;
    end else if (flagWrite) begin
      flagStatus <= (flagStatus & ~storeValue) | hwFlagSet;
    end else begin
      flagStatus <= flagStatus | hwFlagSet;
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile write engine, kept alive through system reset
  // ----------------------------------------------------------------
  localparam NV_IDLE = 1'b0;
  localparam NV_BUSY = 1'b1;

  reg        nvState;
  reg [31:0] nvCount;
  reg        next_nvState;
  reg [31:0] next_nvCount;
  reg        next_nvDone;
  reg        rstSeen;

  // system reset level for the nv engine, caught on the clock
  always @(posedge clk or negedge porRst_b) begin
    if (!porRst_b) begin
      rstSeen <= 1'b0;
    end else begin
      rstSeen <= !rst_b;
    end
  end

  // sequence: start only outside system reset, finish regardless of it
  always @* begin
    next_nvState = nvState;
    next_nvCount = nvCount;
    next_nvDone  = 1'b0;
    case (nvState)
      NV_IDLE: begin
        if (nvWriteStart && !rstSeen && supplyOk) begin
          next_nvState = NV_BUSY;
          next_nvCount = NV_WRITE_CYCLES - 1;
        end
      end
      NV_BUSY: begin
        if (!supplyOk) begin
          next_nvState = NV_IDLE;
          next_nvCount = 32'h0;
        end else if (nvCount == 32'h0) begin
          next_nvState = NV_IDLE;
          next_nvDone  = 1'b1;
        end else begin
          next_nvCount = nvCount - 32'h1;
        end
      end
      default: begin
        next_nvState = NV_IDLE;
        next_nvCount = 32'h0;
      end
    endcase
  end

  // engine flops on power-on reset only
  always @(posedge clk or negedge porRst_b) begin
    if (!porRst_b) begin
      nvState     <= NV_IDLE;
      nvCount     <= 32'h0;
      nvWriteBusy <= 1'b0;
      nvWriteDone <= 1'b0;
    end else begin
      nvState     <= next_nvState;
      nvCount     <= next_nvCount;
      nvWriteBusy <= (next_nvState == NV_BUSY);
      nvWriteDone <= next_nvDone;
    end
  end

endmodule // iosa_access_decode

/* File: rtl/iosa_consts.vh */
`ifndef IOSA_CONSTS_VH
`define IOSA_CONSTS_VH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define IOSA_OP_PORT_READ    3'h0
`define IOSA_OP_PORT_WRITE   3'h1
`define IOSA_OP_DATA_LOAD    3'h2
`define IOSA_OP_DATA_WRITE   3'h3
`define IOSA_OP_BIT_SET      3'h4
`define IOSA_OP_BIT_CLEAR    3'h5
`define IOSA_OP_SKIP_IF_SET  3'h6
`define IOSA_OP_SKIP_IF_CLR  3'h7

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define IOSA_PORT_LAST       8'h3f
`define IOSA_BIT_LAST        8'h1f
`define IOSA_DATA_IO_OFFSET  8'h20
`define IOSA_EXT_FIRST       8'h60
`define IOSA_EXT_LAST        8'hff
`define IOSA_EXT_USED_LAST   8'h9f
`define IOSA_FLAG_ADDR       6'h16
`define IOSA_XMC_A_ADDR      8'h6d
`define IOSA_XMC_B_ADDR      8'h6c

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define IOSA_REG_RESET       8'h00
`define IOSA_NV_WRITE_CYCLES 1000

`endif

/* File: sim/io_space_access_decode_test.sv */
`timescale 1ns/1ps
`include "iosa_consts.vh"
module io_space_access_decode_test;
  reg        clk;
  reg        rst_b;
  reg        porRst_b;
  reg        compatModePin;
  reg        supplyOkPin;
  reg  [7:0] hwFlagSet;
  reg        nvWriteStart;
  wire       opValid;
  wire [2:0] opKind;
  wire [7:0] opAddr;
  wire [2:0] opBit;
  wire [7:0] opWrData;
  wire [7:0] rdData;
  wire       rdValid;
  wire       skipTaken;
  wire       accessError;
  wire [7:0] flagStatus;
  wire [7:0] extMemCtrlA;
  wire [7:0] extMemCtrlB;
  wire       nvWriteBusy;
  wire       nvWriteDone;
  integer    miscompares;
  integer    checksDone;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  iosa_core_model core (.clk(clk), .opValid(opValid), .opKind(opKind), .opAddr(opAddr),
    .opBit(opBit), .opWrData(opWrData));
  iosa_access_decode #(.NV_WRITE_CYCLES(10)) dut (.clk(clk), .rst_b(rst_b),
    .porRst_b(porRst_b), .compatModePin(compatModePin), .supplyOkPin(supplyOkPin),
    .opValid(opValid), .opKind(opKind), .opAddr(opAddr), .opBit(opBit),
    .opWrData(opWrData), .hwFlagSet(hwFlagSet), .nvWriteStart(nvWriteStart),
    .rdData(rdData), .rdValid(rdValid), .skipTaken(skipTaken), .accessError(accessError),
    .flagStatus(flagStatus), .extMemCtrlA(extMemCtrlA), .extMemCtrlB(extMemCtrlB),
    .nvWriteBusy(nvWriteBusy), .nvWriteDone(nvWriteDone));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always #2.5 clk = ~clk;
  task step;
    @(posedge clk) #1;
  endtask
  task check(input [63:0] what, input [7:0] seen, input [7:0] exp);
    begin
      checksDone = checksDone + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task rd(input [2:0] k, input [7:0] a, input [7:0] exp);
    begin
      core.issue(k, a, 3'h0, 8'h00);
      check("rdValid", rdValid, 8'h01);
      check("rdData", rdData, exp);
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task mapTest;
    begin
      core.issue(`IOSA_OP_PORT_WRITE, 8'h05, 3'h0, 8'ha5);
      rd(`IOSA_OP_DATA_LOAD, 8'h25, 8'ha5);
      core.issue(`IOSA_OP_DATA_WRITE, 8'h3f, 3'h0, 8'h3c);
      rd(`IOSA_OP_PORT_READ, 8'h1f, 8'h3c);
      core.issue(`IOSA_OP_PORT_READ, 8'h40, 3'h0, 8'h00);
      check("portErr", accessError, 8'h01);
      core.issue(`IOSA_OP_DATA_WRITE, 8'h70, 3'h0, 8'h81);
      rd(`IOSA_OP_DATA_LOAD, 8'h70, 8'h81);
      core.issue(`IOSA_OP_DATA_WRITE, 8'hb0, 3'h0, 8'hff);
      rd(`IOSA_OP_DATA_LOAD, 8'hb0, 8'h00);
      core.issue(`IOSA_OP_DATA_WRITE, 8'h6d, 3'h0, 8'h5a);
      check("ctrlA", extMemCtrlA, 8'h5a);
      core.issue(`IOSA_OP_DATA_WRITE, 8'h6c, 3'h0, 8'hc6);
      check("ctrlB", extMemCtrlB, 8'hc6);
    end
  endtask
  task bitTest;
    begin
      core.issue(`IOSA_OP_BIT_SET, 8'h05, 3'h6, 8'h00);
      rd(`IOSA_OP_PORT_READ, 8'h05, 8'he5);
      core.issue(`IOSA_OP_BIT_CLEAR, 8'h05, 3'h0, 8'h00);
      rd(`IOSA_OP_PORT_READ, 8'h05, 8'he4);
      core.issue(`IOSA_OP_SKIP_IF_SET, 8'h05, 3'h2, 8'h00);
      check("skipSet", skipTaken, 8'h01);
      core.issue(`IOSA_OP_SKIP_IF_CLR, 8'h05, 3'h2, 8'h00);
      check("skipClr", skipTaken, 8'h00);
      core.issue(`IOSA_OP_BIT_SET, 8'h20, 3'h0, 8'h00);
      check("bitErr", accessError, 8'h01);
    end
  endtask
  task flagTest;
    begin
      step;
      hwFlagSet = 8'h0f;
      step;
      hwFlagSet = 8'h00;
      core.issue(`IOSA_OP_DATA_WRITE, 8'h36, 3'h0, 8'h03);
      check("flagW1c", flagStatus, 8'h0c);
      core.issue(`IOSA_OP_PORT_WRITE, 8'h16, 3'h0, 8'h00);
      check("flagZero", flagStatus, 8'h0c);
      core.issue(`IOSA_OP_SKIP_IF_SET, 8'h16, 3'h3, 8'h00);
      check("flagSkip", skipTaken, 8'h01);
      core.issue(`IOSA_OP_BIT_SET, 8'h16, 3'h7, 8'h00);
      check("flagRmw", flagStatus, 8'h00);
      step;
      hwFlagSet = 8'h30;
      step;
      hwFlagSet = 8'h00;
      core.issue(`IOSA_OP_BIT_CLEAR, 8'h16, 3'h4, 8'h00);
      check("flagRmwC", flagStatus, 8'h10);
    end
  endtask
  task legacyTest;
    begin
      compatModePin = 1'b1;
      repeat (4) step;
      check("ctrlAHid", extMemCtrlA, 8'h00);
      check("ctrlBHid", extMemCtrlB, 8'h00);
      core.issue(`IOSA_OP_DATA_WRITE, 8'hc3, 3'h0, 8'h77);
      rd(`IOSA_OP_DATA_LOAD, 8'hc3, 8'h77);
      compatModePin = 1'b0;
    end
  endtask
  task nvTest;
    integer n;
    begin
      step;
      nvWriteStart = 1'b1;
      step;
      nvWriteStart = 1'b0;
      rst_b = 1'b0;
      step;
      rst_b = 1'b1;
      check("nvBusy", nvWriteBusy, 8'h01);
      n = 0;
      while (nvWriteDone !== 1'b1 && n < 30) begin
        step;
        n = n + 1;
      end
      check("nvDone", nvWriteDone, 8'h01);
      // supply loss mid-write aborts with no done pulse
      step;
      nvWriteStart = 1'b1;
      step;
      nvWriteStart = 1'b0;
      supplyOkPin = 1'b0;
      repeat (4) step;
      check("nvAbort", nvWriteBusy, 8'h00);
      n = 0;
      repeat (12) begin
        step;
        if (nvWriteDone === 1'b1) n = n + 1;
      end
      check("nvNoDone", n[7:0], 8'h00);
      supplyOkPin = 1'b1;
    end
  endtask
  // ------------------------------------------------------------
  // verdict, main sequence and watchdog
  // ------------------------------------------------------------
  task testDone;
    begin
      $display("checks %0d mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    porRst_b = 1'b0;
    compatModePin = 1'b0;
    supplyOkPin = 1'b1;
    hwFlagSet = 8'h00;
    nvWriteStart = 1'b0;
    miscompares = 0;
    checksDone = 0;
    repeat (5) step;
    rst_b = 1'b1;
    porRst_b = 1'b1;
    repeat (3) step;
    mapTest;
    bitTest;
    flagTest;
    legacyTest;
    nvTest;
    testDone;
  end
  // hang guard, far beyond the expected run
  initial begin
    #10000;
    miscompares = miscompares + 1;
    testDone;
  end
endmodule // io_space_access_decode_test

/* File: sim/iosa_access_decode_assertions.sv */
`timescale 1ns/1ps
module iosa_access_decode_assertions #(
  parameter NV_WRITE_CYCLES = 1000
) (
  input wire       clk,
  input wire       rst_b,
  input wire       porRst_b,
  input wire       compatModePin,
  input wire       opValid,
  input wire [2:0] opKind,
  input wire [7:0] opAddr,
  input wire [2:0] opBit,
  input wire [7:0] opWrData,
  input wire [7:0] hwFlagSet,
  input wire       rdValid,
  input wire       skipTaken,
  input wire       accessError,
  input wire [7:0] flagStatus,
  input wire [7:0] extMemCtrlA,
  input wire       nvWriteBusy,
  input wire       nvWriteDone
);
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  reg  [15:0] busyCnt;
  wire        testBit  = flagStatus[opBit] ^ opKind[0];
  wire [7:0]  keptFlag = flagStatus & (8'h01 << opBit);
  wire        flagOp   = opValid && opKind >= 3'h4 && opAddr == 8'h16;
  // busy length counter, survives system reset
  always @(posedge clk or negedge porRst_b) begin
    if (!porRst_b) busyCnt <= 16'h0;
    else if (nvWriteBusy) busyCnt <= busyCnt + 16'h1;
    else busyCnt <= 16'h0;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence legacyHeld; compatModePin [*5]; endsequence
  sequence flagWrite; opValid && opKind == 3'h3 && opAddr == 8'h36; endsequence
  port_range_a: assert property (
    opValid && opKind <= 3'h1 && opAddr > 8'h3f |=> accessError) else $error("port range");
  bit_range_a: assert property (
    opValid && opKind >= 3'h4 && opAddr > 8'h1f |=> accessError) else $error("bit range");
  data_load_a: assert property (
    opValid && opKind == 3'h2 && opAddr >= 8'h20 |=> rdValid && !accessError)
    else $error("data load");
  flag_write_a: assert property (
    flagWrite |=> flagStatus == (($past(flagStatus) & ~$past(opWrData)) | $past(hwFlagSet)))
    else $error("flag write");
  bit_set_a: assert property (
    flagOp && opKind == 3'h4 |=> flagStatus == $past(hwFlagSet)) else $error("bit set");
  bit_clear_a: assert property (
    flagOp && opKind == 3'h5 |=> flagStatus == ($past(keptFlag) | $past(hwFlagSet)))
    else $error("bit clear");
  skip_test_a: assert property (
    flagOp && opKind[1] |=> skipTaken == $past(testBit) && !accessError)
    else $error("skip test");
  legacy_hide_a: assert property (
    legacyHeld |-> extMemCtrlA == 8'h00) else $error("legacy hide");
  nv_finish_a: assert property (
    @(posedge clk) disable iff (!porRst_b) nvWriteDone |-> busyCnt == NV_WRITE_CYCLES)
    else $error("nv finish");
endmodule // iosa_access_decode_assertions

bind iosa_access_decode iosa_access_decode_assertions #(
  .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) chk (.clk(clk), .rst_b(rst_b), .porRst_b(porRst_b), .compatModePin(compatModePin),
  .opValid(opValid), .opKind(opKind), .opAddr(opAddr), .opBit(opBit), .opWrData(opWrData),
  .hwFlagSet(hwFlagSet), .rdValid(rdValid), .skipTaken(skipTaken),
  .accessError(accessError), .flagStatus(flagStatus), .extMemCtrlA(extMemCtrlA),
  .nvWriteBusy(nvWriteBusy), .nvWriteDone(nvWriteDone));

/* File: sim/iosa_core_model.sv */
`timescale 1ns/1ps
module iosa_core_model (
  input  wire       clk,
  output reg        opValid,
  output reg  [2:0] opKind,
  output reg  [7:0] opAddr,
  output reg  [2:0] opBit,
  output reg  [7:0] opWrData
);
  // idle request lines
  initial begin
    opValid  = 1'b0;
    opKind   = 3'h0;
    opAddr   = 8'h00;
    opBit    = 3'h0;
    opWrData = 8'h00;
  end
  // one request, held for one edge
  task issue(input [2:0] k, input [7:0] a, input [2:0] b, input [7:0] d);
    begin
      @(posedge clk) #1;
      opValid  = 1'b1;
      opKind   = k;
      opAddr   = a;
      opBit    = b;
      opWrData = d;
      @(posedge clk) #1;
      opValid  = 1'b0;
      opAddr   = ~opAddr;
      opWrData = ~opWrData;
    end
  endtask
endmodule // iosa_core_model
